// ### common/adc_ctrl_pkg.sv
// Constants, phases and result carrier for the dual-slope converter control
package adc_ctrl_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // Phase lengths are given in clock periods
    localparam logic [12:0] ZERO_CYCLES = 13'd4000;
    localparam logic [12:0] OFFSET_MAX_CYCLES = 13'd800;
    localparam logic [12:0] RAMP_CYCLES = 13'd4000;
    localparam logic [2:0] RESET_HOLD_CYCLES = 3'd5;
    localparam logic [11:0] FULL_SCALE_COUNT = 12'd1999;
    localparam logic [11:0] UNDER_RANGE_COUNT = 12'd180;
    localparam logic [6:0] DIGIT_PERIOD = 7'd80;
    localparam logic [6:0] BLANK_CYCLES = 7'd2;
    localparam int NUM_DIGITS = 4;
    // Register byte addresses
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam logic [3:0] RESULT_OFFSET = 4'h8;
    localparam int CTRL_RESTART_BIT = 0;
    localparam int CTRL_AUTO_UPDATE_BIT = 1;
    localparam logic CTRL_AUTO_UPDATE_RESET = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        PH_ZERO_FIRST = 3'b000,
        PH_OFFSET = 3'b001,
        PH_ZERO_SECOND = 3'b010,
        PH_RAMP_UP = 3'b011,
        PH_RAMP_DOWN = 3'b100,
        PH_SETTLE = 3'b101
    } phase_e;

    typedef struct packed {
        logic negative;
        logic over;
        logic under;
        logic [3:0] thou;
        logic [3:0] hund;
        logic [3:0] tens;
        logic [3:0] units;
        logic [11:0] count;
    } result_s;
endpackage

// ### hdl/adc_digit_ctrl.sv
// Conversion sequencer, result latches and multiplexed digit scan
//
// Overview of operation
// - Reference low five clocks restarts conversion
// - Update edge before ramp-down loads latches
// - One end-of-conversion pulse per cycle
// - Overrange output low when input exceeds reference
// - Digit select high only for its digit
// - Scan starts at half digit after EOC
// - Two blank clocks between digit selects
// - Digit advances every eighty clocks
// - Digits two to four carry decimal digits
// - Bit three low for leading one
// - Bit two high for positive reading
// - Bit zero flags out of range
// - First digit pattern follows fixed table
// - Clock from oscillator or external source
// - Overrange when count exceeds 1999
// - Underrange when count below 180
// - Six phases, 16002 to 17600 clocks
`timescale 1ns/1ns
`default_nettype none
module adc_digit_ctrl
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog front end
    input wire logic ref_at_neg_in,
    input wire logic comparator_trip_in,
    input wire logic input_negative_in,
    // Display side
    input wire logic display_update_in,
    output logic eoc_out,
    output logic over_range_n,
    output logic digit_select_msd,
    output logic digit_select_second,
    output logic digit_select_third,
    output logic digit_select_lsd,
    output logic bcd_bit_zero,
    output logic bcd_bit_one,
    output logic bcd_bit_two,
    output logic bcd_bit_three
);
    phase_e phase_ff;
    logic [12:0] cnt_ff;
    logic [12:0] offset_ff;
    logic [2:0] ref_low_ff;
    logic restart;
    logic sign_ff;
    logic counting_ff;
    logic [11:0] count_ff;
    logic [3:0] bcd_run_ff [NUM_DIGITS];
    logic [3:0] nxt_bcd [NUM_DIGITS];
    logic du_prev_ff;
    logic armed_ff;
    logic end_cycle;
    result_s result_ff;
    logic [6:0] scan_ff;
    logic [1:0] digit_ff;
    logic [NUM_DIGITS-1:0] sel_ff;
    logic [3:0] bcd_ff;
    logic soft_restart_ff;
    logic auto_update_ff;
    logic [3:0] awaddr_ff;
    logic [7:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic second_prev_ff;
    logic [6:0] rate_cnt_ff;

    // Reference held low long enough restarts the sequence
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !ref_at_neg_in)
            ref_low_ff <= 3'd0;
        else if (ref_low_ff != RESET_HOLD_CYCLES)
            ref_low_ff <= ref_low_ff + 3'd1;
    end
    assign restart = (ref_at_neg_in && ref_low_ff >= RESET_HOLD_CYCLES - 3'd1)
        || soft_restart_ff;
    assign end_cycle = (phase_ff == PH_SETTLE) && (cnt_ff == RAMP_CYCLES - 13'd1) && !restart;

    // Six-phase conversion sequencer
    always_ff @(posedge aclk)
    begin
        if (!aresetn || restart)
        begin
            phase_ff <= PH_ZERO_FIRST;
            cnt_ff <= 13'd0;
            offset_ff <= 13'd0;
            sign_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= cnt_ff + 13'd1;
            case (phase_ff)
                PH_ZERO_FIRST, PH_ZERO_SECOND:
                    if (cnt_ff == ZERO_CYCLES - 13'd1)
                    begin
                        phase_ff <= (phase_ff == PH_ZERO_FIRST) ? PH_OFFSET : PH_RAMP_UP;
                        cnt_ff <= 13'd0;
                        sign_ff <= input_negative_in;
                    end
                PH_OFFSET:
                    if (comparator_trip_in || cnt_ff == OFFSET_MAX_CYCLES - 13'd1)
                    begin
                        phase_ff <= PH_ZERO_SECOND;
                        offset_ff <= cnt_ff;
                        cnt_ff <= 13'd0;
                    end
                PH_RAMP_UP:
                    if (cnt_ff == RAMP_CYCLES - 13'd1)
                    begin
                        phase_ff <= PH_RAMP_DOWN;
                        cnt_ff <= 13'd0;
                    end
                PH_RAMP_DOWN:
                    if (cnt_ff >= offset_ff)
                    begin
                        phase_ff <= PH_SETTLE;
                        cnt_ff <= 13'd0;
                    end
                PH_SETTLE:
                    if (end_cycle)
                    begin
                        phase_ff <= PH_ZERO_FIRST;
                        cnt_ff <= 13'd0;
                    end
                default:
                begin
                    phase_ff <= PH_ZERO_FIRST;
                    cnt_ff <= 13'd0;
                end
            endcase
        end
    end

    // Decimal ripple increment of the running count
    always_comb
    begin
        logic carry;
        carry = 1'b1;
        for (int i = NUM_DIGITS - 1; i >= 0; i--)
        begin
            nxt_bcd[i] = bcd_run_ff[i];
            if (carry)
            begin
                nxt_bcd[i] = (bcd_run_ff[i] == 4'h9) ? 4'h0 : bcd_run_ff[i] + 4'h1;
                carry = (bcd_run_ff[i] == 4'h9);
            end
        end
    end

    // Result count runs until the integrator returns to threshold
    always_ff @(posedge aclk)
    begin
        if (!aresetn || restart || phase_ff != PH_SETTLE)
        begin
            counting_ff <= (phase_ff == PH_RAMP_DOWN) && aresetn && !restart;
            count_ff <= 12'd0;
            for (int i = 0; i < NUM_DIGITS; i++)
                bcd_run_ff[i] <= 4'h0;
        end
        else if (counting_ff)
        begin
            counting_ff <= !comparator_trip_in;
            if (!comparator_trip_in)
            begin
                count_ff <= count_ff + 12'd1;
                bcd_run_ff <= nxt_bcd;
            end
        end
    end

    // Update edge arms the latches only before ramp-down
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            du_prev_ff <= 1'b0;
            armed_ff <= 1'b0;
        end
        else
        begin
            du_prev_ff <= display_update_in;
            if (display_update_in && !du_prev_ff && phase_ff < PH_RAMP_DOWN)
                armed_ff <= 1'b1;
            else if (end_cycle || restart)
                armed_ff <= 1'b0;
        end
    end

    // Output latches and end-of-conversion pulse
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            result_ff <= '0;
            over_range_n <= 1'b1;
            eoc_out <= 1'b0;
        end
        else
        begin
            eoc_out <= end_cycle;
            if (end_cycle && (armed_ff || auto_update_ff))
            begin
                result_ff.negative <= sign_ff;
                result_ff.over <= count_ff > FULL_SCALE_COUNT;
                result_ff.under <= count_ff < UNDER_RANGE_COUNT;
                result_ff.thou <= bcd_run_ff[0];
                result_ff.hund <= bcd_run_ff[1];
                result_ff.tens <= bcd_run_ff[2];
                result_ff.units <= bcd_run_ff[3];
                result_ff.count <= count_ff;
                over_range_n <= !(count_ff > FULL_SCALE_COUNT);
            end
        end
    end

    // Digit scan, restarted at the half digit by each conversion end
    always_ff @(posedge aclk)
    begin
        if (!aresetn || end_cycle)
        begin
            scan_ff <= 7'd0;
            digit_ff <= 2'd0;
        end
        else if (scan_ff == DIGIT_PERIOD - 7'd1)
        begin
            scan_ff <= 7'd0;
            digit_ff <= digit_ff + 2'd1;
        end
        else
            scan_ff <= scan_ff + 7'd1;
    end

    generate
        for (genvar d = 0; d < NUM_DIGITS; d++)
        begin : g_sel
            always_ff @(posedge aclk)
            begin
                if (!aresetn || end_cycle)
                    sel_ff[d] <= 1'b0;
                else
                    sel_ff[d] <= (digit_ff == 2'(d)) && (scan_ff >= BLANK_CYCLES);
            end
        end
    endgenerate
    assign digit_select_msd = sel_ff[0];
    assign digit_select_second = sel_ff[1];
    assign digit_select_third = sel_ff[2];
    assign digit_select_lsd = sel_ff[3];

    // Data changes only at scan position zero, inside the blank gap
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            bcd_ff <= 4'h0;
        else if (scan_ff == 7'd0)
            case (digit_ff)
                2'd0: bcd_ff <= {!(result_ff.over || result_ff.thou == 4'h1),
                    !result_ff.negative,
                    result_ff.over || result_ff.thou != 4'h1,
                    result_ff.over || result_ff.under};
                2'd1: bcd_ff <= result_ff.hund;
                2'd2: bcd_ff <= result_ff.tens;
                2'd3: bcd_ff <= result_ff.units;
                default: bcd_ff <= 4'h0;
            endcase
    end
    assign {bcd_bit_three, bcd_bit_two, bcd_bit_one, bcd_bit_zero} = bcd_ff;

    // AXI4-Lite write channel; address and data taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            soft_restart_ff <= 1'b0;
            auto_update_ff <= CTRL_AUTO_UPDATE_RESET;
        end
        else
        begin
            soft_restart_ff <= 1'b0;
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awready <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wready <= 1'b0;
            if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= RESP_SLVERR;
                if (awaddr_ff == CTRL_OFFSET)
                begin
                    s_axi_bresp <= RESP_OKAY;
                    if (wstrb_ff[0])
                    begin
                        soft_restart_ff <= wdata_ff[CTRL_RESTART_BIT];
                        auto_update_ff <= wdata_ff[CTRL_AUTO_UPDATE_BIT];
                    end
                end
                else if (awaddr_ff == STATUS_OFFSET || awaddr_ff == RESULT_OFFSET)
                    s_axi_bresp <= RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awaddr_ff <= 4'h0;
            wdata_ff <= 8'h00;
            wstrb_ff <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
                awaddr_ff <= {s_axi_awaddr[3:2], 2'b00};
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_ff <= s_axi_wdata[7:0];
                wstrb_ff <= s_axi_wstrb;
            end
        end
    end

    // AXI4-Lite read channel, answer one cycle after the address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case ({s_axi_araddr[3:2], 2'b00})
                CTRL_OFFSET: s_axi_rdata <= {30'd0, auto_update_ff, 1'b0};
                STATUS_OFFSET: s_axi_rdata <= {26'd0, digit_ff, armed_ff, phase_ff};
                RESULT_OFFSET: s_axi_rdata <= {17'd0, result_ff.under, result_ff.over,
                    result_ff.negative, result_ff.count};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    a_hold_restarts: assert property (@(posedge aclk) disable iff (!aresetn)
        ref_at_neg_in [*5] |=> (phase_ff == PH_ZERO_FIRST && cnt_ff == 13'd0))
        else $error("reference hold did not restart conversion");
    a_eoc_single_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        eoc_out |=> !eoc_out [*3])
        else $error("end of conversion pulse too long");
    a_eoc_at_end: assert property (@(posedge aclk) disable iff (!aresetn)
        (phase_ff == PH_SETTLE && cnt_ff == RAMP_CYCLES - 13'd1 && !restart)
        |=> eoc_out && phase_ff == PH_ZERO_FIRST)
        else $error("conversion end without pulse");
    a_select_onehot: assert property (@(posedge aclk) disable iff (!aresetn)
        $onehot0(sel_ff))
        else $error("more than one digit selected");
    a_bcd_stable_sel: assert property (@(posedge aclk) disable iff (!aresetn)
        (sel_ff != 4'h0 && $past(sel_ff) == sel_ff) |-> $stable(bcd_ff))
        else $error("data changed while digit selected");
    // A conversion end inside the gap restarts the scan and lengthens the gap
    a_blank_gap_two: assert property (@(posedge aclk) disable iff (!aresetn)
        ($fell(|sel_ff) && !eoc_out) |-> (sel_ff == 4'h0) ##1 (sel_ff == 4'h0)
        ##1 (sel_ff != 4'h0 || eoc_out || $past(eoc_out)))
        else $error("blanking gap not two clocks");
    a_msd_after_eoc: assert property (@(posedge aclk) disable iff (!aresetn)
        eoc_out |-> ##3 digit_select_msd)
        else $error("half digit not first after conversion end");
    a_msd_code: assert property (@(posedge aclk) disable iff (!aresetn)
        digit_select_msd |-> (bcd_bit_zero == (result_ff.over || result_ff.under)
        && bcd_bit_two == !result_ff.negative))
        else $error("half digit pattern wrong");
    // Cycles since the second digit rose; a scan restart voids the count
    always_ff @(posedge aclk)
    begin
        second_prev_ff <= digit_select_second;
        if (!aresetn || eoc_out)
            rate_cnt_ff <= 7'h00;
        else if (digit_select_second && !second_prev_ff)
            rate_cnt_ff <= 7'h01;
        else if (rate_cnt_ff != 7'h00 && rate_cnt_ff != 7'h7F)
            rate_cnt_ff <= rate_cnt_ff + 7'h01;
    end
    a_mux_rate: assert property (@(posedge aclk) disable iff (!aresetn)
        ($rose(digit_select_third) && rate_cnt_ff != 7'h00) |-> rate_cnt_ff == DIGIT_PERIOD)
        else $error("digit period not eighty clocks");
endmodule // adc_digit_ctrl
`default_nettype wire

// ### testbench/display_sampler.sv
// Display-side model: samples the multiplexed digits the way a decoder would
`timescale 1ns/1ns
`default_nettype none
module display_sampler (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Converter outputs, selects ordered msd down to lsd
    input wire logic eoc_out,
    input wire logic [3:0] sel,
    input wire logic [3:0] bcd,
    // Update wiring
    input wire logic tie_update,
    input wire logic manual_update,
    output logic display_update_in,
    // Observations
    output logic [15:0] shown,
    output logic [6:0] high_len,
    output logic [6:0] gap_len,
    output logic [7:0] faults
);
    logic [3:0] sel_d;
    logic [3:0] bcd_d;
    logic [3:0] last;
    logic [3:0] nxt_sel;
    logic [6:0] run;
    logic fresh;
    assign display_update_in = tie_update ? eoc_out : manual_update;
    assign nxt_sel = (fresh || last == 4'h1) ? 4'h8 : last >> 1;
    always_ff @(posedge aclk)
    begin
        sel_d <= sel;
        bcd_d <= bcd;
        run <= (sel == sel_d) ? run + 7'h01 : 7'h01;
        if (!aresetn)
        begin
            fresh <= 1'b1;
            last <= 4'h1;
            faults <= 8'h00;
            shown <= 16'h0000;
        end
        else
        begin
            if (eoc_out)
                fresh <= 1'b1;
            if (sel != 4'h0 && sel_d == 4'h0)
            begin
                gap_len <= run;
                last <= sel;
                fresh <= 1'b0;
                if (sel != nxt_sel)
                    faults <= faults + 8'h01;
            end
            if (sel == 4'h0 && sel_d != 4'h0)
                high_len <= run;
            // A digit cut short by a scan restart may change data, so it is excused
            if (sel != 4'h0 && sel == sel_d && bcd != bcd_d && !fresh)
                faults <= faults + 8'h01;
            for (int i = 0; i < 4; i++)
                if (sel[i])
                    shown[4*i +: 4] <= bcd;
        end
    end
endmodule // display_sampler
`default_nettype wire

// ### testbench/dual_slope_adc_digit_mux_control_tb_top.sv
// Self-checking bench for the converter sequencing and digit scan
`timescale 1ns/1ns
`default_nettype none
module dual_slope_adc_digit_mux_control_tb_top;
    import adc_ctrl_pkg::*;
    // Settle window start after an end pulse, with both offsets at their maximum
    localparam int SETTLE_START = 13600;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic ref_at_neg_in = 1'b0, comparator_trip_in = 1'b0, input_negative_in = 1'b0;
    logic tie = 1'b0, man = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire eoc_out, over_range_n, display_update_in;
    wire digit_select_msd, digit_select_second, digit_select_third, digit_select_lsd;
    wire bcd_bit_zero, bcd_bit_one, bcd_bit_two, bcd_bit_three;
    wire [3:0] sel, bcd;
    wire [15:0] shown;
    wire [6:0] high_len, gap_len;
    wire [7:0] faults;
    int num_errors = 0, n_compared = 0, t = 0, xt = 30000, p, k;
    logic [31:0] seed = 32'h00012857;
    logic [31:0] d, x;
    logic [1:0] r;
    assign sel = {digit_select_msd, digit_select_second, digit_select_third, digit_select_lsd};
    assign bcd = {bcd_bit_three, bcd_bit_two, bcd_bit_one, bcd_bit_zero};
    adc_digit_ctrl i_adc_digit_ctrl (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ref_at_neg_in, .comparator_trip_in,
        .input_negative_in, .display_update_in, .eoc_out, .over_range_n,
        .digit_select_msd, .digit_select_second, .digit_select_third, .digit_select_lsd,
        .bcd_bit_zero, .bcd_bit_one, .bcd_bit_two, .bcd_bit_three);
    display_sampler i_display_sampler (
        .aclk, .aresetn, .eoc_out, .sel, .bcd, .tie_update(tie), .manual_update(man),
        .display_update_in, .shown, .high_len, .gap_len, .faults);
    always #5 aclk = ~aclk;
    // Integrator model: threshold reached a set number of clocks after each end pulse
    always @(posedge aclk)
    begin
        t <= (eoc_out === 1'b1) ? 0 : t + 1;
        comparator_trip_in <= (t >= xt);
    end
    function automatic logic [31:0] rnd();
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            return seed;
        end
    endfunction
    function automatic logic [15:0] exp_disp(input int c, input logic ng);
        logic ov;
        logic one;
        begin
            ov = c > 1999;
            one = (c / 1000) == 1;
            return {~(ov | one), ~ng, ov | ~one, ov | (c < 180), 4'(c / 100 % 10),
                4'(c / 10 % 10), 4'(c % 10)};
        end
    endfunction
    task automatic end_of_test();
        begin
            $display("errors %0d compared %0d", num_errors, n_compared);
            if (num_errors == 0 && n_compared > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            n_compared++;
            if (got !== exp)
            begin
                num_errors++;
                $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
            end
        end
    endtask
    task automatic bound(input int n, input int lim);
        begin
            if (n >= lim)
            begin
                num_errors++;
                end_of_test();
            end
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
        int n;
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= v;
            s_axi_wstrb <= 4'hF;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            n = 0;
            do
            begin
                @(posedge aclk);
                n++;
                if (s_axi_awready === 1'b1)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wready === 1'b1)
                    s_axi_wvalid <= 1'b0;
            end
            while (s_axi_bvalid !== 1'b1 && n < 100);
            bound(n, 100);
            s_axi_bready <= 1'b0;
            chk(s_axi_bresp, er);
        end
    endtask
    task automatic rd(input logic [3:0] a);
        int n;
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            n = 0;
            do
            begin
                @(posedge aclk);
                n++;
                if (s_axi_arready === 1'b1)
                    s_axi_arvalid <= 1'b0;
            end
            while (s_axi_rvalid !== 1'b1 && n < 100);
            bound(n, 100);
            s_axi_rready <= 1'b0;
            d = s_axi_rdata;
            r = s_axi_rresp;
        end
    endtask
    task automatic wait_eoc();
        int n;
        begin
            n = 0;
            do
            begin
                @(posedge aclk);
                n++;
            end
            while (eoc_out !== 1'b1 && n < 20000);
            bound(n, 20000);
            p = t + 1;
            @(posedge aclk);
            chk(eoc_out, 1'b0);
        end
    endtask
    // Waits out one full scan so every digit has been seen afresh
    task automatic check_disp(input int c, input logic ng);
        logic [15:0] e;
        begin
            e = exp_disp(c, ng);
            repeat (330) @(posedge aclk);
            if (c > 1999)
                chk(shown[15:12], e[15:12]);
            else
                chk(shown, e);
            chk(high_len, 7'd78);
            chk(gap_len, 7'd2);
            chk(faults, 8'h00);
            chk(over_range_n, (c > 1999) ? 1'b0 : 1'b1);
        end
    endtask
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk({over_range_n, eoc_out, sel, bcd}, 10'h200);
        rd(CTRL_OFFSET);
        chk(d, 32'h0);
        repeat (4300) @(posedge aclk);
        ref_at_neg_in <= 1'b1;
        repeat (4) @(posedge aclk);
        ref_at_neg_in <= 1'b0;
        rd(STATUS_OFFSET);
        chk(d[2:0], PH_OFFSET);
        ref_at_neg_in <= 1'b1;
        repeat (5) @(posedge aclk);
        ref_at_neg_in <= 1'b0;
        rd(STATUS_OFFSET);
        chk(d[2:0], PH_ZERO_FIRST);
        wr(CTRL_OFFSET, 32'h2, RESP_OKAY);
        x = rnd();
        wr(4'hC, x, RESP_SLVERR);
        rd(4'hC);
        chk(r, RESP_SLVERR);
        chk(d, 32'h0);
        rd(CTRL_OFFSET);
        chk(d, 32'h2);
        wait_eoc();
        x = rnd();
        xt <= SETTLE_START + 1000;
        input_negative_in <= x[0];
        tie <= 1'b1;
        wait_eoc();
        chk(p, 17600);
        tie <= 1'b0;
        rd(RESULT_OFFSET);
        // Fixed sampling latency of the trip input, measured once and reused
        k = 1000 - int'(d[11:0]);
        chk(k >= -3 && k <= 3, 1'b1);
        xt <= SETTLE_START + 2000 + k;
        input_negative_in <= 1'b1;
        wr(CTRL_OFFSET, 32'h0, RESP_OKAY);
        check_disp(int'(d[11:0]), x[0]);
        wait_eoc();
        chk(p, 17600);
        xt <= SETTLE_START + 1999 + k;
        rd(RESULT_OFFSET);
        chk(d[14:12], 3'b011);
        check_disp(2000, 1'b1);
        wait_eoc();
        chk(p, 17600);
        xt <= SETTLE_START + 179 + k;
        input_negative_in <= 1'b0;
        check_disp(2000, 1'b1);
        x = rnd();
        repeat (x % 2000) @(posedge aclk);
        man <= 1'b1;
        wait_eoc();
        rd(RESULT_OFFSET);
        chk(d[14:0], 15'h40B3);
        check_disp(179, 1'b0);
        end_of_test();
    end
endmodule // dual_slope_adc_digit_mux_control_tb_top
`default_nettype wire
